// [sbc_conv_ctrl.sv]
// Spectral bank conversion control with AHB-Lite register slave
// Behaviour
// R1 - Every channel integrates its photodiode current into a 16-bit result.
// R2 - Results move into data registers through a double buffer, never mixed.
// R3 - Two groups of four photodiodes each; other two results read zero.
// R4 - One group takes one period; both groups take two periods.
// R5 - Integration period never below 2.8 ms.
// R6 - Conversions repeat continuously, fresh data each period. In mode two the code gives fresh data every two periods.
// R7 - Mode zero, main device fills S T U V; R W read zero.
// R8 - Mode zero, second fills G H K I; third fills A B E C.
// R9 - Mode one, main device fills R T U W; S V read zero.
// R10 - Mode one, second fills G H J L; third fills F A B D.
// R11 - Mode two, all six channels of every device valid.
// R12 - Host should service ready promptly in mode two.
// R13 - Companions are reached only through this block's registers.
// R14 - All timing derives from the single on-chip clock.
// R15 - Temperature sampled continuously, latest value readable.
// R16 - Reset pin low over 100 ms resets block and second device.
// R17 - During firmware update the lamp flashes with 500 ms pulses.
// R18 - Lamp switchable by host with 1, 2, 4 or 8 mA sink.
// R19 - Ready after one period in modes 0/1, two in mode 2.
// R20 - With interrupts on, ready pulls alert low and sets ready flag.
// R21 - Result read clears ready flag; control read releases alert.
// R22 - Multi-byte result stays unchanged once its read has begun.
// R23 - Three mode values; a change applies at the next cycle start.
`timescale 1ns/100ps
`default_nettype none
`include "sbc_map.svh"
module sbc_conv_ctrl #(
  parameter int unsigned RST_HOLD_CYC = `SBC_RST_HOLD_NS / `SBC_CLK_NS,
  parameter int unsigned BLINK_CYC = `SBC_BLINK_NS / `SBC_CLK_NS,
  parameter int unsigned TICK_CYC = `SBC_TICK_NS / `SBC_CLK_NS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire sbc_pkg::sbc_pd_t pd_current,
  input wire logic [11:0] temp_code,
  input wire logic active_low_reset_pin,
  output logic companion_rst_n,
  output logic host_alert_n,
  output sbc_pkg::sbc_lamp_t indicator_lamp_output
);
  import sbc_pkg::*;

  // R14 rates derived from the one clock
  localparam logic [9:0] TICK_LAST = 10'(TICK_CYC - 1);
  localparam logic [15:0] MIN_IT =
    16'((`SBC_MIN_IT_NS + `SBC_TICK_NS - 1) / `SBC_TICK_NS);
  localparam logic [19:0] RST_LAST = 20'(RST_HOLD_CYC);
  localparam logic [22:0] BLINK_LAST = 23'(BLINK_CYC - 1);
  localparam logic [17:0] G0_MASK =
    {`SBC_G0_COMP, `SBC_G0_COMP, `SBC_G0_MAIN};
  localparam logic [17:0] G1_MASK =
    {`SBC_G1_COMP, `SBC_G1_COMP, `SBC_G1_MAIN};

  logic rp_s1_q, rp_s2_q, long_rst_q, srst;
  logic [19:0] rh_cnt_q;
  logic [9:0] tdiv_q;
  logic tick;
  logic dphase_q, dwr_q, rdy_q;
  logic [7:0] daddr_q, doff;
  logic [4:0] didx;
  logic take, wr_go, rd_go, is_data, copy_busy;
  logic [31:0] reg_rdata_q;
  logic [15:0] mem_rdata;
  logic int_en_q, lamp_on_q, fw_q;
  logic [1:0] cur_q;
  sbc_mode_t mode_q, cyc_mode_q;
  logic [15:0] intv_q, intv_cyc_q, per_cnt_q;
  logic [11:0] temp_q;
  sbc_seq_t state_q;
  logic start_q, grp_q;
  logic [4:0] cidx_q;
  logic [17:0] cmask_q, int_en_mask;
  sbc_acc_t acc;
  logic mem_we, ready_ev;
  logic [15:0] mem_wdata;
  logic ready_q, alert_q;
  logic [22:0] blink_cnt_q;
  logic blink_q;

  // Reset pin synchroniser, the pin is asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rp_s1_q <= 1'b1;
      rp_s2_q <= 1'b1;
    end else begin
      rp_s1_q <= active_low_reset_pin;
      rp_s2_q <= rp_s1_q;
    end
  end

  // R16 long-low detector; short glitches never reset anything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rh_cnt_q <= 20'h00000;
      long_rst_q <= 1'b0;
    end else if (rp_s2_q) begin
      rh_cnt_q <= 20'h00000;
      long_rst_q <= 1'b0;
    end else if (rh_cnt_q != RST_LAST) begin
      rh_cnt_q <= rh_cnt_q + 20'h00001;
    end else begin
      long_rst_q <= 1'b1;
    end
  end

  assign srst = long_rst_q;
  // R16 second device held in reset with this one
  assign companion_rst_n = !long_rst_q;

  // R14 100 us tick, realigned at each cycle start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdiv_q <= 10'h000;
    end else if (start_q || tick) begin
      tdiv_q <= 10'h000;
    end else begin
      tdiv_q <= tdiv_q + 10'h001;
    end
  end
  assign tick = (tdiv_q == TICK_LAST);

  // Bus address phase capture; held while a data phase waits
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_q <= 1'b0;
      dwr_q <= 1'b0;
      daddr_q <= 8'h00;
    end else if (hready) begin
      dphase_q <= take;
      if (take) begin
        dwr_q <= hwrite;
        daddr_q <= haddr[7:0];
      end
    end
  end

  // Result window decode, one word per channel
  assign doff = daddr_q - `SBC_DATA_OFS;
  assign didx = doff[6:2];
  assign is_data = (daddr_q >= `SBC_DATA_OFS) && (doff[7:2] < 6'h12);
  assign copy_busy = (state_q == SEQ_COPY);
  assign wr_go = dphase_q && dwr_q;
  // R2 result reads wait out a transfer in progress
  assign rd_go = dphase_q && !dwr_q && !rdy_q && !(is_data && copy_busy);

  // Reads take one wait state, result reads more during a copy; writes none
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= rd_go;
    end
  end
  assign hreadyout = !dphase_q || dwr_q || rdy_q;
  assign hresp = 1'b0;
  assign hrdata = is_data ? {16'h0000, mem_rdata} : reg_rdata_q;

  // Register read data, unmapped words read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_rdata_q <= 32'h00000000;
    end else if (rd_go) begin
      case (daddr_q)
        `SBC_CTRL_OFS: reg_rdata_q <= {25'h0000000, fw_q, cur_q,
                                       lamp_on_q, mode_q, int_en_q};
        `SBC_INTV_OFS: reg_rdata_q <= {16'h0000, intv_q};
        `SBC_STAT_OFS: reg_rdata_q <= {29'h00000000, grp_q, alert_q,
                                       ready_q};
        `SBC_TEMP_OFS: reg_rdata_q <= {20'h00000, temp_q};
        default: reg_rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Control register writes; R13 companions follow these settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_en_q <= 1'b0;
      mode_q <= MODE_G0;
      lamp_on_q <= 1'b0;
      cur_q <= 2'h0;
      fw_q <= 1'b0;
    end else if (srst) begin
      int_en_q <= 1'b0;
      mode_q <= MODE_G0;
      lamp_on_q <= 1'b0;
      cur_q <= 2'h0;
      fw_q <= 1'b0;
    end else if (wr_go && daddr_q == `SBC_CTRL_OFS) begin
      int_en_q <= hwdata[`SBC_CTRL_INTEN];
      // R23 the unused fourth code is ignored
      if (hwdata[`SBC_CTRL_MODE+:2] != 2'h3) begin
        mode_q <= sbc_mode_t'(hwdata[`SBC_CTRL_MODE+:2]);
      end
      // R18 lamp switch and sink current code
      lamp_on_q <= hwdata[`SBC_CTRL_LAMP];
      cur_q <= hwdata[`SBC_CTRL_CUR+:2];
      fw_q <= hwdata[`SBC_CTRL_FW];
    end
  end

  // R5 period clamped to its floor on write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      intv_q <= `SBC_INTV_RST;
    end else if (srst) begin
      intv_q <= `SBC_INTV_RST;
    end else if (wr_go && daddr_q == `SBC_INTV_OFS) begin
      intv_q <= (hwdata[15:0] < MIN_IT) ? MIN_IT : hwdata[15:0];
    end
  end

  // R15 temperature refreshed every tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_q <= 12'h000;
    end else if (tick) begin
      temp_q <= temp_code;
    end
  end

  // R6 free-running conversion sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= SEQ_RUN_A;
      start_q <= 1'b1;
      cyc_mode_q <= MODE_G0;
      intv_cyc_q <= `SBC_INTV_RST;
      per_cnt_q <= `SBC_INTV_RST;
      grp_q <= 1'b0;
      cidx_q <= 5'h00;
      cmask_q <= 18'h00000;
    end else if (srst) begin
      state_q <= SEQ_RUN_A;
      start_q <= 1'b1;
      cidx_q <= 5'h00;
    end else if (start_q) begin
      // R23 mode and period latched only here
      start_q <= 1'b0;
      cyc_mode_q <= mode_q;
      intv_cyc_q <= intv_q;
      per_cnt_q <= intv_q;
      grp_q <= (mode_q == MODE_G1);
      // R3 zero mask chosen per mode
      unique case (mode_q)
        MODE_G0: cmask_q <= G0_MASK;
        MODE_G1: cmask_q <= G1_MASK;
        MODE_BOTH: cmask_q <= G0_MASK | G1_MASK;
      endcase
    end else begin
      unique case (state_q)
        SEQ_RUN_A: begin
          if (tick && per_cnt_q == 16'h0001) begin
            // R4 second group gets a full period of its own
            if (cyc_mode_q == MODE_BOTH) begin
              state_q <= SEQ_RUN_B;
              grp_q <= 1'b1;
              per_cnt_q <= intv_cyc_q;
            end else begin
              state_q <= SEQ_COPY;
            end
          end else if (tick) begin
            per_cnt_q <= per_cnt_q - 16'h0001;
          end
        end
        SEQ_RUN_B: begin
          if (tick && per_cnt_q == 16'h0001) begin
            state_q <= SEQ_COPY;
          end else if (tick) begin
            per_cnt_q <= per_cnt_q - 16'h0001;
          end
        end
        SEQ_COPY: begin
          cidx_q <= cidx_q + 5'h01;
          if (cidx_q == 5'h11) begin
            cidx_q <= 5'h00;
            state_q <= SEQ_RUN_A;
            start_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // R1 only the active group integrates; shared diodes once in mode two
  assign int_en_mask = (state_q == SEQ_COPY) ? 18'h00000 :
                       !grp_q ? G0_MASK :
                       (cyc_mode_q == MODE_BOTH) ? (G1_MASK & ~G0_MASK) :
                       G1_MASK;

  sbc_integrator u_integ (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(start_q),
    .stb(tick),
    .en(int_en_mask),
    .cur(pd_current),
    .acc(acc)
  );

  // R2 finished results copied into the read buffer
  assign mem_we = copy_busy;
  // R7 R8 R9 R10 R11 unused channels forced to zero
  assign mem_wdata = cmask_q[cidx_q] ? acc[cidx_q] : 16'h0000;
  // R19 ready at the end of the copy, after one or two periods
  assign ready_ev = copy_busy && (cidx_q == 5'h11);

  // R22 read data taken whole into a register, so later copies cannot change it
  sbc_result_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(mem_we),
    .waddr(cidx_q),
    .wdata(mem_wdata),
    .re(rd_go && is_data),
    .raddr(didx),
    .rdata(mem_rdata)
  );

  // R20 R21 ready flag and alert; a new event beats a clearing read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b0;
      alert_q <= 1'b0;
    end else if (srst) begin
      ready_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      if (ready_ev) begin
        ready_q <= 1'b1;
      end else if (rd_go && is_data) begin
        ready_q <= 1'b0;
      end
      if (ready_ev && int_en_q) begin
        alert_q <= 1'b1;
      end else if (rd_go && daddr_q == `SBC_CTRL_OFS) begin
        alert_q <= 1'b0;
      end
    end
  end
  assign host_alert_n = !alert_q;

  // R17 flash timer, parked while no update runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt_q <= 23'h000000;
      blink_q <= 1'b0;
    end else if (!fw_q || srst) begin
      blink_cnt_q <= 23'h000000;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == BLINK_LAST) begin
      blink_cnt_q <= 23'h000000;
      blink_q <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 23'h000001;
    end
  end

  // R17 R18 lamp output, update flashing overrides host control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      indicator_lamp_output <= '0;
    end else begin
      indicator_lamp_output.sink_en <= fw_q ? blink_q : lamp_on_q;
      indicator_lamp_output.cur_sel <= cur_q;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  intv_floor_a: assert property (intv_q >= MIN_IT) // R5
    else $error("period below floor");
  alert_drop_a: assert property ( // R20
    ready_ev && int_en_q && !srst |=> !host_alert_n ##0 ready_q)
    else $error("alert not raised on ready");
  ready_clr_a: assert property ( // R21
    rd_go && is_data && !ready_ev && !srst |=> !ready_q)
    else $error("ready not cleared by read");
  alert_rel_a: assert property ( // R21
    rd_go && daddr_q == `SBC_CTRL_OFS && !ready_ev |=> host_alert_n)
    else $error("alert not released");
  copy_block_a: assert property ( // R2
    rd_go && is_data |-> state_q != SEQ_COPY)
    else $error("result read during copy");
  two_period_a: assert property ( // R4
    state_q == SEQ_RUN_B |-> cyc_mode_q == MODE_BOTH)
    else $error("second period outside mode two");
  mode_hold_a: assert property ( // R23
    !start_q |=> $stable(cyc_mode_q))
    else $error("mode changed mid cycle");
  zero_fill_a: assert property ( // R3
    mem_we && !cmask_q[cidx_q] |-> mem_wdata == 16'h0000)
    else $error("unused channel not zero");
  copy_len_a: assert property (disable iff (!hresetn || srst) // R6
    $rose(copy_busy) |-> copy_busy [*8] ##1 copy_busy [*8] ##1
    copy_busy [*2] ##1 !copy_busy)
    else $error("copy length wrong");
  comp_rst_a: assert property ( // R16
    long_rst_q |-> !companion_rst_n)
    else $error("companion not reset");
  lamp_host_a: assert property ( // R18
    $past(!fw_q) |-> indicator_lamp_output.sink_en == $past(lamp_on_q))
    else $error("lamp ignores host");

  both_cov: cover property (ready_ev && cyc_mode_q == MODE_BOTH);
  g1_cov: cover property (ready_ev && cyc_mode_q == MODE_G1);
  read_cov: cover property (rd_go && is_data && ready_q);
  blink_cov: cover property (fw_q && $rose(blink_q));

endmodule : sbc_conv_ctrl
`default_nettype wire

// [sbc_integrator.sv]
// Per-channel saturating integrators of photodiode current codes
`timescale 1ns/100ps
`default_nettype none
`include "sbc_map.svh"
module sbc_integrator (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clr,
  input wire logic stb,
  input wire logic [17:0] en,
  input wire sbc_pkg::sbc_pd_t cur,
  output sbc_pkg::sbc_acc_t acc
);
  import sbc_pkg::*;

  for (genvar i = 0; i < `SBC_NCH; i++) begin : g_ch
    logic [16:0] sum;
    assign sum = {1'b0, acc[i]} + {9'h000, cur[i]};
    // R1 sixteen-bit integration
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        acc[i] <= 16'h0000;
      end else if (clr) begin
        acc[i] <= 16'h0000;
      end else if (stb && en[i]) begin
        // Saturate rather than wrap on strong light
        acc[i] <= sum[16] ? 16'hFFFF : sum[15:0];
      end
    end
  end

endmodule : sbc_integrator
`default_nettype wire

// [sbc_map.svh]
// Register map, field positions, reset values and timing of the conversion block
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH

// Register byte offsets, low address byte only
`define SBC_CTRL_OFS 8'h00
`define SBC_INTV_OFS 8'h04
`define SBC_STAT_OFS 8'h08
`define SBC_TEMP_OFS 8'h0C
`define SBC_DATA_OFS 8'h40

// Control field positions
`define SBC_CTRL_INTEN 0
`define SBC_CTRL_MODE 1
`define SBC_CTRL_LAMP 3
`define SBC_CTRL_CUR 4
`define SBC_CTRL_FW 6

// Reset values and channel count
`define SBC_INTV_RST 16'h0064
`define SBC_NCH 18

// Group masks, bit i is photodiode i of one device
`define SBC_G0_MAIN 6'h1E
`define SBC_G1_MAIN 6'h2D
`define SBC_G0_COMP 6'h17
`define SBC_G1_COMP 6'h2B

// Timing, in ns
`define SBC_CLK_NS 100
`define SBC_TICK_NS 100000
`define SBC_MIN_IT_NS 2800000
`define SBC_RST_HOLD_NS 100000000
`define SBC_BLINK_NS 500000000

`endif

// [sbc_pkg.sv]
// Types shared by the spectral conversion block
package sbc_pkg;
  typedef logic [17:0][7:0] sbc_pd_t;
  typedef logic [17:0][15:0] sbc_acc_t;
  typedef enum logic [1:0] {
    MODE_G0 = 2'h0,
    MODE_G1 = 2'h1,
    MODE_BOTH = 2'h2
  } sbc_mode_t;
  typedef enum logic [2:0] {
    SEQ_RUN_A = 3'h1,
    SEQ_RUN_B = 3'h2,
    SEQ_COPY = 3'h4
  } sbc_seq_t;
  typedef struct packed {
    logic sink_en;
    logic [1:0] cur_sel;
  } sbc_lamp_t;
endpackage : sbc_pkg

// [sbc_result_mem.sv]
// Result word store with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "sbc_map.svh"
module sbc_result_mem (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic re,
  input wire logic [4:0] raddr,
  output logic [15:0] rdata
);
  import sbc_pkg::*;

  logic [15:0] mem [0:`SBC_NCH-1];

  // Write port, no reset needed on storage
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= 16'h0000;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule : sbc_result_mem
`default_nettype wire

// [sbc_sensor_model.sv]
// Photodiode and temperature front end feeding the conversion block
`timescale 1ns/100ps
`default_nettype none
module sbc_sensor_model (
  input wire logic hclk,
  input wire sbc_pkg::sbc_pd_t level,
  input wire logic [11:0] temp,
  output sbc_pkg::sbc_pd_t pd_current,
  output logic [11:0] temp_code
);
  import sbc_pkg::*;

  // one current per channel
  // Codes change only after an edge, so the block never samples a moving value
  always_ff @(posedge hclk) begin
    pd_current <= level;
  end

  // temperature follows sensor
  // The die temperature is a level that the block may sample at any tick
  always_ff @(posedge hclk) begin
    temp_code <= temp;
  end
endmodule : sbc_sensor_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the spectral bank conversion control block
`timescale 1ns/100ps
`default_nettype none
`include "sbc_map.svh"
module testbench;
  import sbc_pkg::*;
  localparam int RHC = 20;
  localparam int BLC = 10;
  localparam int TKC = 10;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic pin_n = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, comp_rst_n, alert_n;
  logic [31:0] hrdata, rd;
  sbc_lamp_t lamp;
  sbc_pd_t lvl = '0;
  sbc_pd_t pd;
  logic [11:0] tmp = 12'h0;
  logic [11:0] tcode;
  int fails = 0, checked = 0, cyc = 0, t_last = 0, g = 0;

  // Free-running clock and a cycle count for period measurements
  always #50 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  sbc_sensor_model u_sbc_sensor_model (.hclk(hclk), .level(lvl), .temp(tmp),
    .pd_current(pd), .temp_code(tcode));

  sbc_conv_ctrl #(.RST_HOLD_CYC(RHC), .BLINK_CYC(BLC), .TICK_CYC(TKC))
    u_sbc_conv_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pd_current(pd), .temp_code(tcode),
    .active_low_reset_pin(pin_n), .companion_rst_n(comp_rst_n),
    .host_alert_n(alert_n), .indicator_lamp_output(lamp));

  // Verdict and end of run, also reached when a wait runs out
  task automatic complete_run();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_pin

  // One AHB-Lite single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic late;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    late = (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (late || hreadyout !== 1'b1) begin
      fails++;
      complete_run();
    end
  endtask : bus

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp_reg(rd, e);
  endtask : chk

  // Polls the ready flag; the long bound covers the slow first period
  task automatic wait_ready();
    int n;
    n = 0;
    do begin bus(1'b0, `SBC_STAT_OFS, 32'h0); n++; end
      while (rd[0] !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      fails++;
      complete_run();
    end
  endtask : wait_ready

  // Expected result of channel i, from the channel letters of each mode
  function automatic logic [15:0] exp_ch(input int m, input int i, input int per);
    logic [5:0] msk;
    if (m == 0) msk = (i < 6) ? 6'h1E : 6'h17;
    else if (m == 1) msk = (i < 6) ? 6'h2D : 6'h2B;
    else msk = 6'h3F;
    return msk[i % 6] ? 16'(16'(lvl[i]) * 16'(per)) : 16'h0;
  endfunction : exp_ch

  // Reads all eighteen results; each covers one period, shared diodes too
  task automatic check_data(input int m, input int per);
    logic [15:0] e;
    for (int i = 0; i < 18; i++) begin
      bus(1'b0, 8'(8'h40 + 4 * i), 32'h0);
      e = exp_ch(m, i, per);
      cmp_reg(rd, {16'h0, e});
    end
  endtask : check_data

  task automatic flip_gap();
    logic s;
    s = lamp.sink_en;
    g = 0;
    while (lamp.sink_en === s && g < 100) begin @(negedge hclk); g++; end
  endtask : flip_gap

  initial begin
    rd = $urandom(32'h8011);
    @(posedge hclk);
    for (int i = 0; i < 18; i++) lvl[i] <= 8'($urandom_range(255, 1));
    lvl[0] <= 8'hFF;
    tmp <= 12'($urandom);
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped place, response code
    chk(`SBC_CTRL_OFS, 32'h0);
    chk(`SBC_INTV_OFS, 32'h64);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    chk(8'h20, 32'h0);
    cmp_pin({3'h0, hresp}, 4'h0);
    $display("test reset_values done");
    // Period floor, a random legal period, then the shortest one
    bus(1'b1, `SBC_INTV_OFS, 32'h5);
    chk(`SBC_INTV_OFS, 32'd28);
    g = $urandom_range(300, 28);
    bus(1'b1, `SBC_INTV_OFS, 32'(g));
    chk(`SBC_INTV_OFS, 32'(g));
    bus(1'b1, `SBC_INTV_OFS, 32'd28);
    // Mode code three is refused, other fields still land
    bus(1'b1, `SBC_CTRL_OFS, 32'h7);
    chk(`SBC_CTRL_OFS, 32'h1);
    bus(1'b1, `SBC_CTRL_OFS, 32'h2);
    chk(`SBC_CTRL_OFS, 32'h2);
    $display("test period_mode done");
    // Lamp on at every sink current, then off
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `SBC_CTRL_OFS, 32'(32'hA | (k << 4)));
      repeat (2) @(negedge hclk);
      cmp_pin({1'b0, lamp}, 4'(4'h4 | k));
    end
    bus(1'b1, `SBC_CTRL_OFS, 32'h2);
    repeat (2) @(negedge hclk);
    cmp_pin({1'b0, lamp.sink_en, 2'h0}, 4'h0);
    // Flashing during an update, stopped when it ends
    bus(1'b1, `SBC_CTRL_OFS, 32'h42);
    flip_gap();
    flip_gap();
    cmp_reg(32'(g), 32'(BLC));
    bus(1'b1, `SBC_CTRL_OFS, 32'h2);
    repeat (3 * BLC) @(negedge hclk);
    cmp_pin({3'h0, lamp.sink_en}, 4'h0);
    $display("test lamp done");
    // First period: reset length, mode zero, alert masked
    wait_ready();
    t_last = cyc;
    @(negedge hclk);
    cmp_pin({3'h0, alert_n}, 4'h1);
    check_data(0, 100);
    bus(1'b0, `SBC_STAT_OFS, 32'h0);
    cmp_pin({3'h0, rd[0]}, 4'h0);
    bus(1'b1, `SBC_CTRL_OFS, 32'h5);
    chk(`SBC_TEMP_OFS, {20'h0, tmp});
    @(posedge hclk);
    tmp <= 12'($urandom);
    repeat (3 * TKC) @(posedge hclk);
    chk(`SBC_TEMP_OFS, {20'h0, tmp});
    $display("test mode0 done");
    // Second period: mode one at the shortest period, alert raised
    wait_ready();
    g = cyc - t_last;
    t_last = cyc;
    cmp_pin({3'h0, g >= 28 * TKC && g <= 28 * TKC + 60}, 4'h1);
    @(negedge hclk);
    cmp_pin({3'h0, alert_n}, 4'h0);
    bus(1'b0, 8'h40, 32'h0);
    bus(1'b0, `SBC_STAT_OFS, 32'h0);
    cmp_pin({2'h0, rd[1:0]}, 4'h2);
    bus(1'b0, `SBC_CTRL_OFS, 32'h0);
    repeat (2) @(negedge hclk);
    cmp_pin({3'h0, alert_n}, 4'h1);
    check_data(1, 28);
    $display("test mode1 done");
    // Third period: both groups, two periods long
    wait_ready();
    g = cyc - t_last;
    cmp_pin({3'h0, g >= 56 * TKC && g <= 56 * TKC + 60}, 4'h1);
    check_data(2, 28);
    $display("test mode2 done");
    // Short reset pulse is ignored, a long one resets the companion, control and period
    @(posedge hclk);
    pin_n <= 1'b0;
    repeat (10) @(posedge hclk);
    pin_n <= 1'b1;
    repeat (6) @(negedge hclk);
    cmp_pin({3'h0, comp_rst_n}, 4'h1);
    @(posedge hclk);
    pin_n <= 1'b0;
    repeat (RHC + 8) @(negedge hclk);
    cmp_pin({3'h0, comp_rst_n}, 4'h0);
    chk(`SBC_CTRL_OFS, 32'h0);
    @(posedge hclk);
    pin_n <= 1'b1;
    repeat (6) @(negedge hclk);
    cmp_pin({3'h0, comp_rst_n}, 4'h1);
    chk(`SBC_INTV_OFS, 32'h64);
    $display("test long_reset done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
